//--- design/srq_pkg.sv
// Shared types and constants for the serial port queue and pin control core
package srq_pkg;
	localparam int         BYTE_BITS  = 8;
	localparam int         CNT_W      = 4;
	localparam int         DIV_W      = 5;
	localparam int         RATE_MAX   = 3;
	localparam logic [3:0] BYTE_DONE  = 4'h8;
	localparam logic [2:0] BIT_FIRST  = 3'h0;
	localparam logic [2:0] BIT_LAST   = 3'h7;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;

	typedef struct packed {
		logic rx_irq_enable;
		logic master_select;
		logic wired_or_select;
		logic module_on;
		logic tx_irq_enable;
	} srq_ctrl_type;

	localparam srq_ctrl_type CTRL_RESET = '{
		rx_irq_enable:   1'h0,
		master_select:   1'h1,
		wired_or_select: 1'h0,
		module_on:       1'h0,
		tx_irq_enable:   1'h0
	};

	typedef struct packed {
		logic error_irq_enable;
		logic select_conflict_detect_enable;
		logic rate_select_hi;
		logic rate_select_lo;
	} srq_stat_ctrl_type;

	localparam srq_stat_ctrl_type STAT_RESET = '{default: 1'h0};

	typedef struct packed {
		logic rx_full_flag;
		logic overrun_flag;
		logic select_conflict_flag;
		logic tx_buffer_empty_flag;
	} srq_flags_type;

	typedef struct packed {
		logic miso;
		logic mosi;
		logic sck;
		logic ss;
	} srq_pins_type;

	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_LOW  = 2'h1,
		M_HIGH = 2'h3
	} srq_mstate_type;
endpackage

//--- design/srq_sync.sv
// Two-stage synchroniser for a bundle of levels
`timescale 1ns/1ps
module srq_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_arst_n,
	// Levels in and out
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= i_d;
			sync_q <= meta_q;
		end
	end

	assign o_q = sync_q;
endmodule // srq_sync

//--- design/srq_core.sv
// Serial port core: resets, transmit queue and shared pin control
// What this block does
// [R1] Module off: empty flag set, transfer aborted, shifter and counter cleared, pins released.
// [R2] Module off keeps control bits and receive, overrun, conflict flags; only system reset restores their reset values.
// [R3] Master conflict with detection on clears module enable; software may clear it too.
// [R4] Master starts a queued byte right after the previous transfer ends.
// [R5] Software writes data only while the transmit empty flag is high.
// [R6] Slave without new data resends the last shift register contents.
// [R7] Idle module refills empty flag within two clocks after buffer load.
// [R8] Busy slave loads shifter from buffer only after the current byte.
// [R9] In wait mode registers are closed; enabled requests wake the processor.
// [R10] Break with flag-clear enable low makes data writes do nothing.
// [R11] Wired-or select makes MOSI an open-drain output.
// [R12] Slave drives MISO only with master select low and select low.
// [R13] Enabled module owns direction of MISO, MOSI and serial clock.
// [R14] Master drives serial clock, slave takes it; eight clocks per byte.
// [R15] Remote master toggles select between bytes in phase zero format.
// [R16] Slave select always module input in slave mode; detect enable gates conflicts.
// [R17] Slave ignores serial clock edges while select is high.
// [R18] Select is port I/O when off or master without detect; else input.
// [R19] Select level stays readable through the port.
// [R20] Conflict: select rises mid-transfer in slave, or low in master, detect on.
// [R21] Conflict flag clears by status read with flag then control write.
`timescale 1ns/1ps
module srq_core #(
	parameter int BASE_HALF = 2
) (
	// Clocks and reset
	input  wire logic                       i_mclk,
	input  wire logic                       i_arst_n,
	input  wire logic                       i_link_sck,
	// Processor access
	input  wire logic                       i_control_wr,
	input  wire srq_pkg::srq_ctrl_type      i_control,
	input  wire logic                       i_status_ctrl_wr,
	input  wire srq_pkg::srq_stat_ctrl_type i_status_ctrl,
	input  wire logic                       i_status_rd,
	input  wire logic                       i_data_wr,
	input  wire logic [7:0]                 i_data_wdata,
	input  wire logic                       i_data_rd,
	input  wire logic                       i_wait,
	input  wire logic                       i_break,
	input  wire logic                       i_break_flag_clear_enable,
	output srq_pkg::srq_ctrl_type           o_control,
	output srq_pkg::srq_stat_ctrl_type      o_status_ctrl,
	output srq_pkg::srq_flags_type          o_flags,
	output logic [7:0]                      o_rx_data,
	output logic                            o_irq_request,
	output logic                            o_wake_request,
	// Shared pins
	input  wire logic                       i_mosi,
	input  wire logic                       i_miso,
	input  wire logic                       i_ss_n,
	output logic                            o_mosi,
	output logic                            o_mosi_oe_n,
	output logic                            o_miso,
	output logic                            o_miso_oe_n,
	output logic                            o_sck,
	output logic                            o_sck_oe_n,
	output srq_pkg::srq_pins_type           o_port_owned,
	output logic                            o_ss_level
);
	if (BASE_HALF < 2 || (BASE_HALF << srq_pkg::RATE_MAX) > (1 << srq_pkg::DIV_W))
		$error("BASE_HALF out of range");

	srq_pkg::srq_ctrl_type      ctrl_q, ctrl_d;
	srq_pkg::srq_stat_ctrl_type stat_q, stat_d;
	srq_pkg::srq_mstate_type    m_state_q, m_state_d;
	logic [7:0]                 tx_buf_q, tx_buf_d, slave_tx_q, slave_tx_d, rx_data_q, rx_data_d;
	logic [7:0]                 sr_q, sr_d, l_sr_q, l_sr_d, l_rx_q, l_rx_d, done_byte;
	logic                       tx_full_q, tx_full_d, mosi_q, mosi_d, sck_q, sck_d;
	logic [srq_pkg::DIV_W-1:0]  div_q, div_d, half_m1;
	logic [srq_pkg::CNT_W-1:0]  bit_q, bit_d;
	logic [2:0]                 l_bit_q, l_bit_d;
	logic                       rx_full_q, rx_full_d, ovr_q, ovr_d, conf_q, conf_d;
	logic                       rx_arm_q, rx_arm_d, conf_arm_q, conf_arm_d;
	logic                       slave_run_q, slave_run_d, ss_prev_q, ss_prev_d;
	logic                       done_seen_q, done_seen_d, irq_q, irq_d, wake_q, wake_d;
	logic                       l_tgl_q, l_tgl_d, l_busy_q, l_busy_d, link_rst_n;
	logic                       miso_s, ss_s, tgl_s, busy_s;
	logic                       master_cfg, slave_cfg, ctrl_wr, stat_wr, stat_rd, data_rd, data_wr;
	logic                       m_load, m_done, s_load, s_done, byte_done, conf_evt;

	srq_sync #(
		.W (4)
	) u_sync (
		.i_clk    (i_mclk),
		.i_arst_n (i_arst_n),
		.i_d      ({i_miso, i_ss_n, l_tgl_q, l_busy_q}),
		.o_q      ({miso_s, ss_s, tgl_s, busy_s})
	);

	// Configuration and gated processor strobes
	assign master_cfg = ctrl_q.module_on & ctrl_q.master_select;
	assign slave_cfg  = ctrl_q.module_on & ~ctrl_q.master_select;
	assign ctrl_wr    = i_control_wr & ~i_wait;                     // see [R9]
	assign stat_wr    = i_status_ctrl_wr & ~i_wait;
	assign stat_rd    = i_status_rd & ~i_wait;
	assign data_rd    = i_data_rd & ~i_wait;
	assign data_wr    = i_data_wr & ~i_wait & ctrl_q.module_on
		& ~(i_break & ~i_break_flag_clear_enable);                   // see [R10]
	assign half_m1    = srq_pkg::DIV_W'((BASE_HALF << {stat_q.rate_select_hi, stat_q.rate_select_lo}) - 1);

	// Conflict detection on the synchronised select level
	assign conf_evt = stat_q.select_conflict_detect_enable
		& ((master_cfg & ~ss_s)
		| (slave_cfg & ss_s & ~ss_prev_q & busy_s));                 // see [R20] see [R16]

	// Master shift engine
	always_comb
	begin
		m_state_d = m_state_q;
		sr_d      = sr_q;
		mosi_d    = mosi_q;
		sck_d     = sck_q;
		div_d     = div_q;
		bit_d     = bit_q;
		m_load    = 1'b0;
		m_done    = 1'b0;
		case (m_state_q)
			srq_pkg::M_IDLE:
				m_load = master_cfg & tx_full_q;
			srq_pkg::M_LOW:
				if (div_q == half_m1)
				begin
					div_d     = '0;
					sck_d     = 1'b1;
					sr_d      = {sr_q[6:0], miso_s};
					bit_d     = bit_q + srq_pkg::CNT_W'(1);
					m_state_d = srq_pkg::M_HIGH;
				end
				else
					div_d = div_q + srq_pkg::DIV_W'(1);
			srq_pkg::M_HIGH:
				if (div_q == half_m1)
				begin
					div_d = '0;
					sck_d = 1'b0;
					if (bit_q == srq_pkg::BYTE_DONE)                       // see [R14]
					begin
						m_done    = 1'b1;
						m_load    = master_cfg & tx_full_q;                 // see [R4]
						m_state_d = srq_pkg::M_IDLE;
					end
					else
					begin
						mosi_d    = sr_q[7];
						m_state_d = srq_pkg::M_LOW;
					end
				end
				else
					div_d = div_q + srq_pkg::DIV_W'(1);
			default:
				m_state_d = srq_pkg::M_IDLE;
		endcase
		if (m_load)
		begin
			sr_d      = tx_buf_q;
			mosi_d    = tx_buf_q[7];
			bit_d     = '0;
			div_d     = '0;
			m_state_d = srq_pkg::M_LOW;
		end
		if (!master_cfg)                                                // see [R1]
		begin
			m_state_d = srq_pkg::M_IDLE;
			sr_d      = srq_pkg::BYTE_ZERO;
			sck_d     = 1'b0;
			bit_d     = '0;
			div_d     = '0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			m_state_q <= srq_pkg::M_IDLE;
			sr_q      <= srq_pkg::BYTE_ZERO;
			mosi_q    <= 1'b0;
			sck_q     <= 1'b0;
			div_q     <= '0;
			bit_q     <= '0;
		end
		else
		begin
			m_state_q <= m_state_d;
			sr_q      <= sr_d;
			mosi_q    <= mosi_d;
			sck_q     <= sck_d;
			div_q     <= div_d;
			bit_q     <= bit_d;
		end
	end

	// Transmit queue, slave load and flags
	assign s_done    = (tgl_s != done_seen_q) & slave_cfg;
	assign s_load    = slave_cfg & tx_full_q & ~busy_s;               // see [R8]
	assign byte_done = m_done | s_done;
	assign done_byte = m_done ? sr_q : l_rx_q;

	always_comb
	begin
		ctrl_d = ctrl_wr ? i_control : ctrl_q;
		if (conf_evt && master_cfg)
			ctrl_d.module_on = 1'b0;                                      // see [R3]
		stat_d      = stat_wr ? i_status_ctrl : stat_q;                  // see [R2]
		tx_buf_d    = data_wr ? i_data_wdata : tx_buf_q;
		tx_full_d   = ctrl_q.module_on & ((tx_full_q & ~(m_load | s_load)) | data_wr); // see [R1] see [R7]
		slave_tx_d  = slave_tx_q;
		if (s_load)
			slave_tx_d = tx_buf_q;
		else if (s_done && !busy_s)
			slave_tx_d = l_rx_q;                                          // see [R6]
		if (!ctrl_q.module_on)
			slave_tx_d = srq_pkg::BYTE_ZERO;
		rx_data_d   = (byte_done && !rx_full_q) ? done_byte : rx_data_q;
		rx_arm_d    = (stat_rd & (rx_full_q | ovr_q)) | (rx_arm_q & ~data_rd);
		rx_full_d   = byte_done | (rx_full_q & ~(data_rd & rx_arm_q));
		ovr_d       = (byte_done & rx_full_q) | (ovr_q & ~(data_rd & rx_arm_q));
		conf_arm_d  = ~conf_evt & ((stat_rd & conf_q) | (conf_arm_q & ~ctrl_wr));
		conf_d      = conf_evt | (conf_q & ~(ctrl_wr & conf_arm_q));     // see [R21]
		slave_run_d = ctrl_d.module_on & ~ctrl_d.master_select;
		ss_prev_d   = ss_s;
		done_seen_d = tgl_s;
		irq_d       = (ctrl_q.module_on & ctrl_q.tx_irq_enable & ~tx_full_q)
			| (ctrl_q.rx_irq_enable & rx_full_q)
			| (stat_q.error_irq_enable & (ovr_q | conf_q));
		wake_d      = irq_d & i_wait;                                    // see [R9]
	end

	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			ctrl_q      <= srq_pkg::CTRL_RESET;
			stat_q      <= srq_pkg::STAT_RESET;
			tx_buf_q    <= srq_pkg::BYTE_ZERO;
			tx_full_q   <= 1'b0;
			slave_tx_q  <= srq_pkg::BYTE_ZERO;
			rx_data_q   <= srq_pkg::BYTE_ZERO;
			rx_arm_q    <= 1'b0;
			rx_full_q   <= 1'b0;
			ovr_q       <= 1'b0;
			conf_arm_q  <= 1'b0;
			conf_q      <= 1'b0;
			slave_run_q <= 1'b0;
			ss_prev_q   <= 1'b0;
			done_seen_q <= 1'b0;
			irq_q       <= 1'b0;
			wake_q      <= 1'b0;
		end
		else
		begin
			ctrl_q      <= ctrl_d;
			stat_q      <= stat_d;
			tx_buf_q    <= tx_buf_d;
			tx_full_q   <= tx_full_d;
			slave_tx_q  <= slave_tx_d;
			rx_data_q   <= rx_data_d;
			rx_arm_q    <= rx_arm_d;
			rx_full_q   <= rx_full_d;
			ovr_q       <= ovr_d;
			conf_arm_q  <= conf_arm_d;
			conf_q      <= conf_d;
			slave_run_q <= slave_run_d;
			ss_prev_q   <= ss_prev_d;
			done_seen_q <= done_seen_d;
			irq_q       <= irq_d;
			wake_q      <= wake_d;
		end
	end

	// Slave shifter on the link clock, held in reset unless enabled as slave
	assign link_rst_n = i_arst_n & slave_run_q;                         // see [R1]

	always_comb
	begin
		l_sr_d  = l_sr_q;
		l_bit_d = l_bit_q;
		l_rx_d  = l_rx_q;
		l_tgl_d = l_tgl_q;
		if (!i_ss_n)                                                     // see [R17]
		begin
			l_sr_d  = {(l_bit_q == srq_pkg::BIT_FIRST) ? slave_tx_q[6:0] : l_sr_q[6:0], i_mosi};
			l_bit_d = l_bit_q + 3'h1;
			if (l_bit_q == srq_pkg::BIT_LAST)                              // see [R14]
			begin
				l_rx_d  = l_sr_d;
				l_tgl_d = ~l_tgl_q;
			end
		end
		l_busy_d = (l_bit_d != srq_pkg::BIT_FIRST);
	end

	always_ff @(posedge i_link_sck or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			l_sr_q   <= srq_pkg::BYTE_ZERO;
			l_bit_q  <= srq_pkg::BIT_FIRST;
			l_rx_q   <= srq_pkg::BYTE_ZERO;
			l_tgl_q  <= 1'b0;
			l_busy_q <= 1'b0;
		end
		else
		begin
			l_sr_q   <= l_sr_d;
			l_bit_q  <= l_bit_d;
			l_rx_q   <= l_rx_d;
			l_tgl_q  <= l_tgl_d;
			l_busy_q <= l_busy_d;
		end
	end

	// Pin ownership and drivers
	assign o_sck        = sck_q;
	assign o_sck_oe_n   = ~master_cfg;                                  // see [R13] see [R14]
	assign o_mosi       = mosi_q;
	assign o_mosi_oe_n  = ~master_cfg | (ctrl_q.wired_or_select & mosi_q); // see [R11]
	assign o_miso       = (l_bit_q == srq_pkg::BIT_FIRST) ? slave_tx_q[7] : l_sr_q[7];
	assign o_miso_oe_n  = ~(slave_run_q & ~i_ss_n);                     // see [R12]
	assign o_port_owned = '{
		miso: ctrl_q.module_on,
		mosi: ctrl_q.module_on,
		sck:  ctrl_q.module_on,
		ss:   ctrl_q.module_on & (~ctrl_q.master_select | stat_q.select_conflict_detect_enable)
	};                                                                   // see [R18] see [R13]
	assign o_ss_level    = ss_s;                                        // see [R19]
	assign o_control     = ctrl_q;
	assign o_status_ctrl = stat_q;
	assign o_flags       = '{rx_full_q, ovr_q, conf_q, ~tx_full_q};
	assign o_rx_data     = rx_data_q;
	assign o_irq_request = irq_q;
	assign o_wake_request = wake_q;

	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);

	off_empty_a: assert property (!ctrl_q.module_on |=> !tx_full_q && m_state_q == srq_pkg::M_IDLE) // see [R1]
		else $error("disabled module kept data or engine state");
	keep_bits_a: assert property (!ctrl_q.module_on && !stat_wr |=> $stable(stat_q)) // see [R2]
		else $error("status control bits changed while off");
	conflict_off_a: assert property (conf_evt && master_cfg |=> !ctrl_q.module_on && conf_q) // see [R3]
		else $error("master conflict did not disable module");
	queue_restart_a: assert property (m_done && tx_full_q && master_cfg && !conf_evt // see [R4]
		|=> m_state_q == srq_pkg::M_LOW && !sck_q)
		else $error("queued byte not started at once");
	empty_refill_a: assert property (m_load && !data_wr |-> ##[1:2] !tx_full_q) // see [R7]
		else $error("empty flag late after buffer load");
	slave_hold_a: assert property (busy_s && slave_cfg |=> $stable(slave_tx_q)) // see [R8]
		else $error("busy slave shifter reloaded");
	break_write_a: assert property (i_break && !i_break_flag_clear_enable && i_data_wr && !tx_full_q // see [R10]
		|=> !tx_full_q)
		else $error("write in break took effect");
	open_drain_a: assert property (master_cfg && ctrl_q.wired_or_select && mosi_q |-> o_mosi_oe_n) // see [R11]
		else $error("open-drain MOSI driven high");
	miso_drive_a: assert property (!slave_run_q |-> o_miso_oe_n) // see [R12]
		else $error("MISO driven outside slave mode");
	byte_len_a: assert property (m_load |-> ##1 (m_state_q != srq_pkg::M_IDLE || !master_cfg)[*8]) // see [R14]
		else $error("master byte ended early");

	master_done_c: cover property (m_done);
	back_to_back_c: cover property (m_done && m_load);
	slave_done_c: cover property (s_done);
	conflict_c: cover property (conf_evt);
endmodule // srq_core

//--- tb/srq_remote.sv
// Behavioural far-side device: slave to a master core, master to a slave core
`timescale 1ns/1ps
module srq_remote (
	// Serial clock and data from the core as master
	input  wire logic        i_sck,
	input  wire logic        i_sck_active,
	input  wire logic        i_mosi,
	// Data from the core as slave
	input  wire logic        i_miso,
	// Lines driven by this model
	output logic             o_miso,
	output logic             o_mosi,
	output logic             o_sck,
	output logic             o_ss_n,
	output logic [15:0]      o_rx,
	output logic [7:0]       o_rises
);
	logic [7:0] tx_q;
	logic [7:0] reload_q;
	logic [2:0] bit_q;

	initial
	begin
		{o_mosi, o_sck, o_ss_n} = 3'h1;
		{o_rx, o_rises, tx_q, reload_q, bit_q} = '0;
	end
	assign o_miso = tx_q[7];

	// Slave side: sample on the rise, count rises
	always @(posedge i_sck)
		if (i_sck_active)
		begin
			o_rx    <= {o_rx[14:0], i_mosi};
			o_rises <= o_rises + 8'h01;
		end
	// Next bit after the fall, same byte again after the eighth
	always @(negedge i_sck)
		if (i_sck_active)
		begin
			tx_q  <= (bit_q == 3'h7) ? reload_q : {tx_q[6:0], ~tx_q[7]};
			bit_q <= bit_q + 3'h1;
		end

	task automatic load(input logic [7:0] b);
		reload_q = b;
		tx_q     = b;
		bit_q    = 3'h0;
		o_rx     = '0;
		o_rises  = '0;
	endtask

	// Master side: one byte, select low for the byte only, clock still outside it
	task automatic xfer(input logic [7:0] m, input logic sel, output logic [7:0] s);
		o_ss_n = ~sel;
		#230;
		for (int i = 7; i >= 0; i--)
		begin
			o_mosi = m[i];
			#40;
			s[i]  = i_miso;
			o_sck = 1'b1;
			#40;
			o_sck = 1'b0;
		end
		#40;
		o_ss_n = 1'b1;
		o_mosi = ~o_mosi;
		#400;
	endtask
endmodule // srq_remote

//--- tb/spi_reset_queue_and_pin_control_tb.sv
// Self-checking bench for the serial port queue and pin control core
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
`define WAITF(c, n) for (int w = 0; w < (n) && !(c); w++) @(negedge i_mclk);
module spi_reset_queue_and_pin_control_tb;
	logic                       i_mclk, i_arst_n, c_wr, s_wr, s_rd, d_wr, d_rd, wt, brk, break_flag_clear_enable, tb_ss_n;
	logic                       o_mosi, o_mosi_oe_n, o_miso, o_miso_oe_n, o_sck, o_sck_oe_n, o_ss_level, o_wake, o_irq;
	logic                       rem_miso, rem_mosi, rem_sck, rem_ss_n;
	logic [7:0]                 wdata, o_rx_data, sb, b0, b1, m, got;
	logic [31:0]                rnd;
	int                         fail_count, tests_run, cyc;
	srq_pkg::srq_ctrl_type      ctrl, o_control;
	srq_pkg::srq_stat_ctrl_type stat, o_status_ctrl;
	srq_pkg::srq_flags_type     o_flags;
	srq_pkg::srq_pins_type      o_port_owned;
	wire                        mosi_pin = !o_mosi_oe_n ? o_mosi : (o_control.master_select ? 1'b1 : rem_mosi);
	wire                        miso_pin = !o_miso_oe_n ? o_miso : rem_miso;
	wire                        sck_pin  = !o_sck_oe_n ? o_sck : rem_sck;
	wire                        ss_pin   = rem_ss_n & tb_ss_n;

	srq_core DUT (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_link_sck(sck_pin), .i_control_wr(c_wr),
		.i_control(ctrl), .i_status_ctrl_wr(s_wr), .i_status_ctrl(stat), .i_status_rd(s_rd), .i_data_wr(d_wr),
		.i_data_wdata(wdata), .i_data_rd(d_rd), .i_wait(wt), .i_break(brk), .i_break_flag_clear_enable(break_flag_clear_enable),
		.o_control(o_control), .o_status_ctrl(o_status_ctrl), .o_flags(o_flags), .o_rx_data(o_rx_data),
		.o_irq_request(o_irq), .o_wake_request(o_wake), .i_mosi(mosi_pin), .i_miso(miso_pin), .i_ss_n(ss_pin),
		.o_mosi(o_mosi), .o_mosi_oe_n(o_mosi_oe_n), .o_miso(o_miso), .o_miso_oe_n(o_miso_oe_n), .o_sck(o_sck),
		.o_sck_oe_n(o_sck_oe_n), .o_port_owned(o_port_owned), .o_ss_level(o_ss_level));
	srq_remote u_rem (.i_sck(sck_pin), .i_sck_active(!o_sck_oe_n), .i_mosi(mosi_pin), .i_miso(miso_pin),
		.o_miso(rem_miso), .o_mosi(rem_mosi), .o_sck(rem_sck), .o_ss_n(rem_ss_n), .o_rx(), .o_rises());

	function automatic logic [7:0] nxt();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return rnd[7:0];
	endfunction

	function automatic srq_pkg::srq_ctrl_type mk(input logic ms, input logic wo, input logic on, input logic tie);
		mk = '{1'h0, ms, wo, on, tie};
	endfunction

	// One strobe: 0 control, 1 status control, 2 status read, 3 data write, 4 data read
	task automatic pulse(input int k);
		@(negedge i_mclk);
		case (k)
			0: c_wr = 1'b1;
			1: s_wr = 1'b1;
			2: s_rd = 1'b1;
			3: d_wr = 1'b1;
			default: d_rd = 1'b1;
		endcase
		@(negedge i_mclk);
		{c_wr, s_wr, s_rd, d_wr, d_rd} = 5'h00;
		repeat (2) @(negedge i_mclk);
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial i_mclk = 1'b0;
	always #25 i_mclk = ~i_mclk;

	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			finish_test();
		end
	end

	initial
	begin
		{i_arst_n, c_wr, s_wr, s_rd, d_wr, d_rd, wt, brk, break_flag_clear_enable} = 9'h000;
		{tb_ss_n, wdata, fail_count, tests_run, cyc, rnd} = {1'h1, 8'h00, 96'h0, 32'h87369930};
		ctrl = srq_pkg::CTRL_RESET;
		stat = srq_pkg::STAT_RESET;
		repeat (12) @(negedge i_mclk);
		i_arst_n = 1'b1;
		@(negedge i_mclk);
		`CHK(o_control, srq_pkg::CTRL_RESET)
		`CHK(o_status_ctrl, srq_pkg::STAT_RESET)
		`CHK(o_flags, 4'h1)
		`CHK({o_mosi_oe_n, o_miso_oe_n, o_sck_oe_n}, 3'h7)
		`CHK(o_port_owned, 4'h0)
		// Master, wired-or, slowest rate, two bytes queued
		stat = '{1'h1, 1'h0, 1'h1, 1'h1};
		pulse(1);
		ctrl = mk(1'h1, 1'h1, 1'h1, 1'h0);
		pulse(0);
		`CHK(o_port_owned, 4'hE)
		{sb, b0, b1} = {nxt(), nxt(), nxt()};
		u_rem.load(sb);
		wdata = b0;
		pulse(3);
		`WAITF(o_flags.tx_buffer_empty_flag === 1'b1, 1)
		`CHK(o_flags.tx_buffer_empty_flag, 1'b1)
		wdata = b1;
		pulse(3);
		`CHK(o_flags.tx_buffer_empty_flag, 1'b0)
		repeat (16)
		begin
			@(posedge o_sck);
			#1;
			`CHK(o_mosi_oe_n, o_mosi)
		end
		`WAITF(o_flags.overrun_flag === 1'b1, 600)
		repeat (2) @(negedge i_mclk);
		`CHK(u_rem.o_rx, {b0, b1})
		`CHK(u_rem.o_rises, 8'h10)
		`CHK(o_rx_data, sb)
		// Disable in mid-byte: partial reset keeps control and receive flags
		wdata = nxt();
		pulse(3);
		repeat (60) @(negedge i_mclk);
		ctrl = mk(1'h1, 1'h1, 1'h0, 1'h0);
		pulse(0);
		`CHK(o_flags, 4'hD)
		`CHK({o_port_owned, o_sck_oe_n, o_mosi_oe_n}, 6'h03)
		`CHK({o_control, o_status_ctrl}, {ctrl, stat})
		pulse(2);
		pulse(4);
		// Break with flag-clear enable low
		ctrl = mk(1'h1, 1'h0, 1'h1, 1'h0);
		pulse(0);
		brk = 1'b1;
		wdata = nxt();
		pulse(3);
		`CHK({o_flags.tx_buffer_empty_flag, o_sck}, 2'h2)
		brk = 1'b0;
		// Wait mode: enabled request wakes, writes refused
		ctrl = mk(1'h1, 1'h0, 1'h1, 1'h1);
		pulse(0);
		wt = 1'b1;
		repeat (3) @(negedge i_mclk);
		`CHK({o_irq, o_wake}, 2'h3)
		ctrl = mk(1'h0, 1'h0, 1'h0, 1'h0);
		pulse(0);
		`CHK(o_control, mk(1'h1, 1'h0, 1'h1, 1'h1))
		wt = 1'b0;
		// Master select conflict
		stat.select_conflict_detect_enable = 1'b1;
		pulse(1);
		`CHK(o_port_owned.ss, 1'b1)
		tb_ss_n = 1'b0;
		repeat (6) @(negedge i_mclk);
		`CHK({o_flags.select_conflict_flag, o_control.module_on}, 2'h2)
		`CHK({o_port_owned, o_ss_level}, 5'h00)
		tb_ss_n = 1'b1;
		repeat (4) @(negedge i_mclk);
		pulse(2);
		ctrl = mk(1'h0, 1'h0, 1'h1, 1'h0);
		pulse(0);
		`CHK({o_flags.select_conflict_flag, o_ss_level}, 2'h1)
		// Slave transfers, first byte written in break with flag-clear enable high
		`CHK({o_port_owned, o_miso_oe_n}, 5'h1F)
		b0 = nxt();
		wdata = b0;
		{brk, break_flag_clear_enable} = 2'h3;
		pulse(3);
		{brk, break_flag_clear_enable} = 2'h0;
		m = nxt();
		u_rem.xfer(m, 1'b1, got);
		`CHK(got, b0)
		repeat (6) @(negedge i_mclk);
		`CHK({o_rx_data, o_flags.rx_full_flag}, {m, 1'b1})
		pulse(2);
		pulse(4);
		u_rem.xfer(nxt(), 1'b1, got);
		`CHK(got, m)
		pulse(2);
		pulse(4);
		u_rem.xfer(nxt(), 1'b0, got);
		repeat (6) @(negedge i_mclk);
		`CHK(o_flags.rx_full_flag, 1'b0)
		finish_test();
	end
endmodule // spi_reset_queue_and_pin_control_tb
